// [core/phpd_params.svh]
// Purpose: constants for the peak-and-hold pair diagnostic block
// Assumes: 100 MHz core clock
// Notes: register offsets are word addresses on the plain register port
`ifndef PHPD_PARAMS_SVH
`define PHPD_PARAMS_SVH

`define PHPD_CLK_MHZ 100
// overcurrent blanking time in ns, default figure
`define PHPD_BLANK_NS 2000
`define PHPD_BLANK_CYC ((`PHPD_BLANK_NS * `PHPD_CLK_MHZ + 999) / 1000)
// off-state diagnostic filter time in ns, default figure
`define PHPD_DIAG_NS 12400
`define PHPD_DIAG_CYC ((`PHPD_DIAG_NS * `PHPD_CLK_MHZ + 999) / 1000)

`define PHPD_ADDR_CTRL 4'h0
`define PHPD_ADDR_CMD 4'h1
`define PHPD_ADDR_DIAG_A 4'h2
`define PHPD_ADDR_DIAG_B 4'h3
`define PHPD_ADDR_STATE 4'h4

// control register fields
`define PHPD_CTRL_PAIR1_EN 0
`define PHPD_CTRL_PAIR2_EN 1
`define PHPD_CTRL_STRAT1 2
`define PHPD_CTRL_STRAT2 3
`define PHPD_CTRL_SRC_LSB 4
`define PHPD_CTRL_RESET 8'h00

`define PHPD_CODE_OC_PIN 3'h0
`define PHPD_CODE_OC 3'h1
`define PHPD_CODE_STB 3'h2
`define PHPD_CODE_STG 3'h3
`define PHPD_CODE_NO_FAIL 3'h4
`define PHPD_CODE_NO_OC 3'h5
`define PHPD_CODE_NO_OFF 3'h6
`define PHPD_CODE_NO_DIAG 3'h7

`endif

// [core/phpd_pkg.sv]
// Purpose: shared types for the peak-and-hold pair diagnostic block
// Assumes: nothing
// Notes: codes are 3-bit diagnostic latch contents
package phpd_pkg;
    typedef logic [2:0] phpd_code_t;
    typedef enum logic [1:0] {PHPD_OFF_IDLE, PHPD_OFF_RUN, PHPD_OFF_DONE} phpd_off_st_t;
endpackage

// [core/phpd_timer.sv]
// Purpose: restartable down counter with expiry level
// Assumes: start has priority over counting
// Notes: expired stays high until hold drops or the next start
module phpd_timer #(
    parameter int CYCLES = 20
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic start_in,
    input wire logic hold_in,
    output logic expired_out
);
    localparam int W = $clog2(CYCLES + 1);
    logic [W-1:0] cnt_ff;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_ff <= '0;
        end else if (start_in) begin
            cnt_ff <= W'(CYCLES);
        end else if (!hold_in) begin
            cnt_ff <= '0;
        end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end

    // expires only after a start, while held, once the count has run out
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            expired_out <= 1'b0;
        end else begin
            expired_out <= hold_in && !start_in && (expired_out || cnt_ff == W'(1));
        end
    end
endmodule

// [core/phpd_latch.sv]
// Purpose: one channel diagnostic latch with fixed priority
// Assumes: lower code value has higher priority for faults
// Notes: clear is applied first, then a simultaneous new code is merged into the cleared latch
`include "phpd_params.svh"
module phpd_latch
    import phpd_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic clear_in,
    input wire logic upd_in,
    input wire phpd_pkg::phpd_code_t code_in,
    output phpd_pkg::phpd_code_t code_out
);
    phpd_code_t nxt_code;

    function automatic phpd_code_t merge(input phpd_code_t cur, input phpd_code_t nw);
        phpd_code_t r;
        r = cur;
        if (nw < `PHPD_CODE_NO_FAIL) begin
            if (cur >= `PHPD_CODE_NO_FAIL || nw < cur) begin
                r = nw;
            end
        end else if (cur >= `PHPD_CODE_NO_FAIL) begin
            // clean reports combine toward no failure
            if (cur == `PHPD_CODE_NO_DIAG) begin
                r = nw;
            end else if (cur != nw && nw != `PHPD_CODE_NO_DIAG) begin
                r = `PHPD_CODE_NO_FAIL;
            end
        end
        return r;
    endfunction

    always_comb begin
        nxt_code = merge(clear_in ? `PHPD_CODE_NO_DIAG : code_out, code_in);
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            code_out <= `PHPD_CODE_NO_DIAG;
        end else if (upd_in) begin
            code_out <= nxt_code;
        end else if (clear_in) begin
            code_out <= `PHPD_CODE_NO_DIAG;
        end
    end
endmodule

// [core/phpd_core.sv]
// Purpose: peak-and-hold pair control source selection and diagnosis
// Assumes: fault comparator inputs are asynchronous; register port synchronous
// Notes: channels indexed 0..3 for channels 1..4
`include "phpd_params.svh"
module phpd_core
    import phpd_pkg::*;
#(
    parameter int BLANK_CYC = `PHPD_BLANK_CYC,
    parameter int DIAG_CYC = `PHPD_DIAG_CYC
) (
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    input wire logic [3:0] DIRECT_ON_PIN_N_IN,
    input wire logic [3:0] OVERCURRENT_IN,
    input wire logic [3:0] SHORT_TO_BATTERY_IN,
    input wire logic [3:0] SHORT_TO_GROUND_IN,
    input wire logic [3:0] OPEN_LOAD_IN,
    input wire logic [3:0] ABOVE_OPEN_LOAD_THRESHOLD_IN,
    input wire logic [3:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [7:0] REG_RDATA_OUT,
    output logic [3:0] CHANNEL_ON_OUT,
    output logic [3:0] FAST_DISCHARGE_OUT,
    output logic [11:0] DIAG_CODES_OUT
);
    import phpd_pkg::*;

    logic [3:0] pin_s1_ff, pin_s2_ff;
    logic [3:0] oc_s1_ff, oc_s2_ff;
    logic [3:0] stb_s1_ff, stb_s2_ff;
    logic [3:0] stg_s1_ff, stg_s2_ff;
    logic [3:0] ol_s1_ff, ol_s2_ff;
    logic [3:0] vol_s1_ff, vol_s2_ff;
    logic [7:0] ctrl_ff;
    logic [3:0] cmd_ff;
    logic [3:0] cmd_on;
    logic [3:0] prev_on_ff;
    logic [3:0] trip_ff;
    logic [3:0] partner;
    logic [3:0] paired;
    logic [3:0] strat;
    logic [3:0] both_on;
    logic [3:0] both_off;
    logic [3:0] blank_done;
    logic [3:0] diag_done;
    logic [3:0] diag_start;
    logic [3:0] on_upd;
    logic [3:0] clr;
    phpd_code_t on_code [4];
    phpd_code_t off_code [4];
    phpd_code_t new_code [4];
    logic [3:0] upd;
    phpd_code_t latch_q [4];

    // two-stage synchronisers for all pin-side inputs
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            pin_s1_ff <= 4'hf;
            pin_s2_ff <= 4'hf;
            oc_s1_ff <= 4'h0;
            oc_s2_ff <= 4'h0;
            stb_s1_ff <= 4'h0;
            stb_s2_ff <= 4'h0;
            stg_s1_ff <= 4'h0;
            stg_s2_ff <= 4'h0;
            ol_s1_ff <= 4'h0;
            ol_s2_ff <= 4'h0;
            vol_s1_ff <= 4'h0;
            vol_s2_ff <= 4'h0;
        end else begin
            pin_s1_ff <= DIRECT_ON_PIN_N_IN;
            pin_s2_ff <= pin_s1_ff;
            oc_s1_ff <= OVERCURRENT_IN;
            oc_s2_ff <= oc_s1_ff;
            stb_s1_ff <= SHORT_TO_BATTERY_IN;
            stb_s2_ff <= stb_s1_ff;
            stg_s1_ff <= SHORT_TO_GROUND_IN;
            stg_s2_ff <= stg_s1_ff;
            ol_s1_ff <= OPEN_LOAD_IN;
            ol_s2_ff <= ol_s1_ff;
            vol_s1_ff <= ABOVE_OPEN_LOAD_THRESHOLD_IN;
            vol_s2_ff <= vol_s1_ff;
        end
    end

    // register writes
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            ctrl_ff <= `PHPD_CTRL_RESET;
            cmd_ff <= 4'h0;
        end else if (REG_WR_IN) begin
            if (REG_ADDR_IN == `PHPD_ADDR_CTRL) begin
                ctrl_ff <= REG_WDATA_IN;
            end else if (REG_ADDR_IN == `PHPD_ADDR_CMD) begin
                cmd_ff <= REG_WDATA_IN[3:0];
            end
        end
    end

    // register reads, data one cycle after the strobe
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            REG_RDATA_OUT <= 8'h00;
        end else if (REG_RD_IN) begin
            if (REG_ADDR_IN == `PHPD_ADDR_CTRL) begin
                REG_RDATA_OUT <= ctrl_ff;
            end else if (REG_ADDR_IN == `PHPD_ADDR_CMD) begin
                REG_RDATA_OUT <= {4'h0, cmd_ff};
            end else if (REG_ADDR_IN == `PHPD_ADDR_DIAG_A) begin
                REG_RDATA_OUT <= {2'h0, latch_q[1], latch_q[0]};
            end else if (REG_ADDR_IN == `PHPD_ADDR_DIAG_B) begin
                REG_RDATA_OUT <= {2'h0, latch_q[3], latch_q[2]};
            end else if (REG_ADDR_IN == `PHPD_ADDR_STATE) begin
                REG_RDATA_OUT <= {trip_ff, CHANNEL_ON_OUT};
            end else begin
                REG_RDATA_OUT <= 8'h00;
            end
        end else begin
            REG_RDATA_OUT <= 8'h00;
        end
    end

    // readout clears both codes held in the addressed register
    always_comb begin
        clr = 4'h0;
        if (REG_RD_IN && REG_ADDR_IN == `PHPD_ADDR_DIAG_A) begin
            clr = 4'h3;
        end else if (REG_RD_IN && REG_ADDR_IN == `PHPD_ADDR_DIAG_B) begin
            clr = 4'hc;
        end
    end

    // pair grouping: ch1-ch4 (idx 0,3) and ch2-ch3 (idx 1,2)
    always_comb begin
        partner = {cmd_on[0], cmd_on[1], cmd_on[2], cmd_on[3]};
        paired = {ctrl_ff[`PHPD_CTRL_PAIR1_EN], ctrl_ff[`PHPD_CTRL_PAIR2_EN],
                  ctrl_ff[`PHPD_CTRL_PAIR2_EN], ctrl_ff[`PHPD_CTRL_PAIR1_EN]};
        strat = {ctrl_ff[`PHPD_CTRL_STRAT1], ctrl_ff[`PHPD_CTRL_STRAT2],
                 ctrl_ff[`PHPD_CTRL_STRAT2], ctrl_ff[`PHPD_CTRL_STRAT1]};
    end

    // per-channel command from pin or register; no regulation applied
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            cmd_on[i] = ctrl_ff[`PHPD_CTRL_SRC_LSB + i] ? cmd_ff[i] : !pin_s2_ff[i];
        end
        both_on = cmd_on & partner;
        both_off = ~cmd_on & ~partner;
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            prev_on_ff <= 4'h0;
        end else begin
            prev_on_ff <= cmd_on;
        end
    end

    // overcurrent trip holds the fet off until the channel is commanded off
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            trip_ff <= 4'h0;
        end else begin
            trip_ff <= (trip_ff | (oc_s2_ff & cmd_on)) & cmd_on;
        end
    end

    assign CHANNEL_ON_OUT = cmd_on & ~trip_ff;
    // high sides are idx 0 and 1
    assign FAST_DISCHARGE_OUT = {2'b00, vol_s2_ff[1:0] & ~cmd_on[1:0]};

    function automatic int partner_idx(input int i);
        return 3 - i;
    endfunction

    // off-state filter start: own switch-off, or in pair partner turns on alone
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            diag_start[i] = (prev_on_ff[i] && !cmd_on[i])
                || (paired[i] && !cmd_on[i] && partner[i] && !prev_on_ff[partner_idx(i)]);
        end
    end

    // on-state codes and update qualification
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            on_upd[i] = cmd_on[i] && (!paired[i] || partner[i]);
            if (oc_s2_ff[i] && paired[i] && oc_s2_ff[partner_idx(i)]) begin
                on_code[i] = `PHPD_CODE_OC_PIN;
            end else if (oc_s2_ff[i] && !blank_done[i]) begin
                on_code[i] = `PHPD_CODE_OC_PIN;
            end else if (oc_s2_ff[i]) begin
                on_code[i] = `PHPD_CODE_OC;
            end else if (blank_done[i]) begin
                on_code[i] = `PHPD_CODE_NO_OC;
            end else begin
                on_code[i] = `PHPD_CODE_NO_DIAG;
            end
        end
    end

    // off-state codes after the filter time
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (paired[i] && both_off[i]) begin
                off_code[i] = strat[i] ? `PHPD_CODE_NO_DIAG : `PHPD_CODE_NO_OFF;
            end else if (stb_s2_ff[i]) begin
                off_code[i] = `PHPD_CODE_STB;
            end else if (stg_s2_ff[i]) begin
                off_code[i] = `PHPD_CODE_STG;
            end else if (ol_s2_ff[i]) begin
                // open load shares the short-to-battery code
                off_code[i] = `PHPD_CODE_STB;
            end else begin
                off_code[i] = `PHPD_CODE_NO_OFF;
            end
        end
    end

    // combine into one update per channel; merge in latch gives 100
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (on_upd[i]) begin
                new_code[i] = on_code[i];
                upd[i] = on_code[i] != `PHPD_CODE_NO_DIAG;
            end else if (!cmd_on[i] && diag_done[i]) begin
                new_code[i] = off_code[i];
                upd[i] = 1'b1;
            end else begin
                new_code[i] = `PHPD_CODE_NO_DIAG;
                upd[i] = 1'b0;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gen_ch
            phpd_timer #(.CYCLES(BLANK_CYC)) u_blank (
                .clk_in(CLK_IN),
                .resetn_in(RESETN_IN),
                .start_in(cmd_on[g] && !prev_on_ff[g]),
                .hold_in(cmd_on[g]),
                .expired_out(blank_done[g])
            );
            phpd_timer #(.CYCLES(DIAG_CYC)) u_diag (
                .clk_in(CLK_IN),
                .resetn_in(RESETN_IN),
                .start_in(diag_start[g]),
                .hold_in(!cmd_on[g]),
                .expired_out(diag_done[g])
            );
            phpd_latch u_latch (
                .clk_in(CLK_IN),
                .resetn_in(RESETN_IN),
                .clear_in(clr[g]),
                .upd_in(upd[g]),
                .code_in(new_code[g]),
                .code_out(latch_q[g])
            );
            assign DIAG_CODES_OUT[3*g +: 3] = latch_q[g];
        end
    endgenerate
endmodule

// [bench/phpd_core_monitor.sv]
// Purpose: port checks for phpd_core
// Assumes: a source select bit of 1 picks the serial command
// Notes: register writes are snooped to know each channel's command
`include "phpd_params.svh"
module phpd_core_monitor (
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    input wire logic [3:0] DIRECT_ON_PIN_N_IN,
    input wire logic [3:0] OVERCURRENT_IN,
    input wire logic [3:0] ABOVE_OPEN_LOAD_THRESHOLD_IN,
    input wire logic [3:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [7:0] REG_RDATA_OUT,
    input wire logic [3:0] CHANNEL_ON_OUT,
    input wire logic [3:0] FAST_DISCHARGE_OUT,
    input wire logic [11:0] DIAG_CODES_OUT
);
    import phpd_pkg::*;
    logic [7:0] ctrl_ff;
    logic [3:0] cmd_ff;
    logic [3:0] cmd_off;
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            ctrl_ff <= `PHPD_CTRL_RESET;
            cmd_ff <= 4'h0;
        end else if (REG_WR_IN) begin
            if (REG_ADDR_IN == `PHPD_ADDR_CTRL) begin
                ctrl_ff <= REG_WDATA_IN;
            end
            if (REG_ADDR_IN == `PHPD_ADDR_CMD) begin
                cmd_ff <= REG_WDATA_IN[3:0];
            end
        end
    end
    // off as seen through the selected source
    assign cmd_off = (ctrl_ff[7:4] & ~cmd_ff) | (~ctrl_ff[7:4] & DIRECT_ON_PIN_N_IN);
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!RESETN_IN);
    sequence s_read_a;
        REG_RD_IN && REG_ADDR_IN == `PHPD_ADDR_DIAG_A;
    endsequence
    sequence s_read_b;
        REG_RD_IN && REG_ADDR_IN == `PHPD_ADDR_DIAG_B;
    endsequence
    AST_RESET_CODES: assert property ($rose(RESETN_IN) |-> DIAG_CODES_OUT == 12'hfff)
        else $error("latches not cleared by reset");
    AST_READ_A: assert property (s_read_a |=> REG_RDATA_OUT == {2'b00, $past(DIAG_CODES_OUT[5:0])})
        else $error("first readout word wrong");
    AST_READ_B: assert property (s_read_b |=> REG_RDATA_OUT == {2'b00, $past(DIAG_CODES_OUT[11:6])})
        else $error("second readout word wrong");
    AST_FD_LOW_SIDE: assert property (FAST_DISCHARGE_OUT[3:2] == 2'b00)
        else $error("fast discharge on a low side");
    AST_FD_ON: assert property ((CHANNEL_ON_OUT[1:0] & FAST_DISCHARGE_OUT[1:0]) == 2'b00)
        else $error("fast discharge while high side on");
    for (genvar i = 0; i < 4; i++) begin : g_ch
        AST_OC_TRIP: assert property (OVERCURRENT_IN[i] [*5] |-> !CHANNEL_ON_OUT[i])
            else $error("channel stays on under overcurrent");
        AST_OFF_CMD: assert property (cmd_off[i] [*4] |-> !CHANNEL_ON_OUT[i])
            else $error("channel on against its selected command");
        AST_FD_RAISE: assert property ((ABOVE_OPEN_LOAD_THRESHOLD_IN[i] && cmd_off[i]) [*4]
            |-> FAST_DISCHARGE_OUT[i] == (i < 2))
            else $error("fast discharge not raised");
    end
endmodule
bind phpd_core phpd_core_monitor mon_u (
    .CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .DIRECT_ON_PIN_N_IN(DIRECT_ON_PIN_N_IN),
    .OVERCURRENT_IN(OVERCURRENT_IN), .ABOVE_OPEN_LOAD_THRESHOLD_IN(ABOVE_OPEN_LOAD_THRESHOLD_IN),
    .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN),
    .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT), .CHANNEL_ON_OUT(CHANNEL_ON_OUT),
    .FAST_DISCHARGE_OUT(FAST_DISCHARGE_OUT), .DIAG_CODES_OUT(DIAG_CODES_OUT)
);

// [bench/phpd_mcu_model.sv]
// Purpose: behavioural controller on the far side of phpd_core
// Assumes: one register access at a time
// Notes: the bench calls these tasks
`include "phpd_params.svh"
module phpd_mcu_model (
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    output logic [3:0] addr_out,
    output logic [7:0] wdata_out,
    output logic wr_out,
    output logic rd_out,
    output logic [3:0] pin_n_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import phpd_pkg::*;
    initial begin
        addr_out = 4'h0;
        wdata_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
        pin_n_out = 4'hf;
    end
    task automatic reg_write(input logic [3:0] addr, input logic [7:0] data);
        @(posedge clk_in);
        addr_out <= addr;
        wdata_out <= data;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] addr, output logic [7:0] data);
        @(posedge clk_in);
        addr_out <= addr;
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        #1;
        data = rdata_in;
    endtask
    // software closes the current loop through the pins
    task automatic drive_pins(input logic [3:0] v);
        @(posedge clk_in);
        pin_n_out <= v;
    endtask
    // both sides at pin overcurrent means a shorted load
    function automatic logic load_short(input phpd_code_t hs, input phpd_code_t ls);
        return hs === `PHPD_CODE_OC_PIN && ls === `PHPD_CODE_OC_PIN;
    endfunction
endmodule

// [bench/test_peak_hold_pair_diagnostics.sv]
// Purpose: self-checking bench for phpd_core
// Assumes: shortened blanking and filter counts
// Notes: load comparators driven here, pins and bus by the controller model
`include "phpd_params.svh"
module test_peak_hold_pair_diagnostics;
    timeunit 1ns;
    timeprecision 1ns;
    import phpd_pkg::*;
    localparam int BLANK = 10;
    localparam int DIAG = 16;
    localparam int W_ON = BLANK + 12;
    localparam int W_OFF = DIAG + 12;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] over_cur = 4'h0;
    logic [3:0] bat_short = 4'h0;
    logic [3:0] gnd_short = 4'h0;
    logic [3:0] open_load = 4'h0;
    logic [3:0] above = 4'h0;
    logic [3:0] addr, pin_n, chon, fd;
    logic [7:0] wdata, rdata, d, ctrl;
    logic wr, rd;
    logic [11:0] codes;
    logic [1:0] st;
    int error_cnt = 0;
    int checked = 0;
    always #5 clk = ~clk;
    phpd_core #(.BLANK_CYC(BLANK), .DIAG_CYC(DIAG)) dut_u (
        .CLK_IN(clk), .RESETN_IN(resetn), .DIRECT_ON_PIN_N_IN(pin_n), .OVERCURRENT_IN(over_cur),
        .SHORT_TO_BATTERY_IN(bat_short), .SHORT_TO_GROUND_IN(gnd_short),
        .OPEN_LOAD_IN(open_load), .ABOVE_OPEN_LOAD_THRESHOLD_IN(above), .REG_ADDR_IN(addr),
        .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
        .CHANNEL_ON_OUT(chon), .FAST_DISCHARGE_OUT(fd), .DIAG_CODES_OUT(codes)
    );
    phpd_mcu_model mcu_u (.clk_in(clk), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
        .wr_out(wr), .rd_out(rd), .pin_n_out(pin_n));
    function automatic phpd_code_t code_of(input int ch);
        return codes[3 * ch +: 3];
    endfunction
    // settled code: ran says a clean on phase happened
    function automatic phpd_code_t exp_idle(input int ch, input logic ran);
        logic s;
        s = (ch == 0 || ch == 3) ? st[0] : st[1];
        if (ran) begin
            return s ? `PHPD_CODE_NO_OC : `PHPD_CODE_NO_FAIL;
        end
        return s ? `PHPD_CODE_NO_DIAG : `PHPD_CODE_NO_OFF;
    endfunction
    function automatic logic [3:0] exp_on(input logic [3:0] s, c, p);
        return (s & c) | (~s & ~p);
    endfunction
    task automatic chk_code(input phpd_code_t got, input phpd_code_t exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t code %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cmd(input logic [3:0] v);
        mcu_u.reg_write(`PHPD_ADDR_CMD, {4'h0, v});
    endtask
    task automatic clear_all();
        mcu_u.reg_read(`PHPD_ADDR_DIAG_A, d);
        mcu_u.reg_read(`PHPD_ADDR_DIAG_B, d);
    endtask
    task automatic load(input logic [3:0] o, input logic [3:0] l, input logic [3:0] a);
        @(posedge clk);
        over_cur <= o;
        open_load <= l;
        above <= a;
    endtask
    task automatic wrap_up();
        if (error_cnt == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'h1c59));
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        tick(1);
        mcu_u.reg_read(`PHPD_ADDR_DIAG_B, d);
        chk_vec(d, 8'h3f);
        mcu_u.reg_read(4'hf, d);
        chk_vec(d, 8'h00);
        st = 2'($urandom);
        ctrl = {4'hf, st, 2'b11};
        mcu_u.reg_write(`PHPD_ADDR_CTRL, ctrl);
        mcu_u.drive_pins(4'($urandom));
        cmd(4'b0011);
        cmd(4'b0000);
        tick(W_OFF);
        for (int c = 0; c < 4; c++) begin
            chk_code(code_of(c), exp_idle(c, 1'b0));
        end
        clear_all();
        cmd(4'hf);
        tick(W_ON);
        cmd(4'h0);
        tick(W_OFF);
        for (int c = 0; c < 4; c++) begin
            chk_code(code_of(c), exp_idle(c, 1'b1));
        end
        clear_all();
        cmd(4'hf);
        load(4'b0001, 4'h0, 4'h0);
        tick(W_ON);
        load(4'b0011, 4'h0, 4'h0);
        tick(8);
        chk_code(code_of(0), `PHPD_CODE_OC_PIN);
        chk_code(code_of(1), `PHPD_CODE_OC);
        chk_vec({4'h0, chon}, 8'h0c);
        load(4'h0, 4'h0, 4'h0);
        cmd(4'h0);
        tick(2);
        cmd(4'hf);
        tick(W_ON);
        cmd(4'h0);
        tick(W_OFF);
        chk_code(code_of(3), exp_idle(3, 1'b1));
        mcu_u.reg_read(`PHPD_ADDR_DIAG_A, d);
        chk_vec(d, {2'b00, `PHPD_CODE_OC, `PHPD_CODE_OC_PIN});
        clear_all();
        cmd(4'b0001);
        load(4'b0001, 4'h0, 4'h0);
        tick(W_ON);
        chk_vec({4'h0, chon}, 8'h00);
        chk_vec({7'h0, code_of(0) inside {3'h0, 3'h1}}, 8'h00);
        load(4'h0, 4'h0, 4'h0);
        cmd(4'h0);
        clear_all();
        cmd(4'b0110);
        tick(W_ON);
        load(4'b0110, 4'h0, 4'h0);
        tick(8);
        chk_code(code_of(1), `PHPD_CODE_OC_PIN);
        chk_code(code_of(2), `PHPD_CODE_OC_PIN);
        chk_vec({7'h0, mcu_u.load_short(code_of(1), code_of(2))}, 8'h01);
        // open load shares the short-to-battery code
        load(4'h0, 4'b1001, 4'h0);
        cmd(4'h0);
        clear_all();
        tick(W_OFF);
        chk_vec({7'h0, code_of(3) == `PHPD_CODE_STB}, 8'h00);
        cmd(4'b0001);
        tick(W_OFF);
        chk_code(code_of(3), `PHPD_CODE_STB);
        load(4'h0, 4'h0, 4'hf);
        cmd(4'h0);
        tick(6);
        chk_vec({4'h0, fd}, 8'h03);
        cmd(4'b0001);
        tick(6);
        chk_vec({4'h0, fd}, 8'h02);
        load(4'h0, 4'h0, 4'h0);
        for (int i = 0; i < 24; i++) begin
            ctrl = 8'($urandom);
            d = 8'($urandom);
            mcu_u.reg_write(`PHPD_ADDR_CTRL, ctrl);
            cmd(d[3:0]);
            mcu_u.drive_pins(d[7:4]);
            tick(5);
            chk_vec({4'h0, chon}, {4'h0, exp_on(ctrl[7:4], d[3:0], d[7:4])});
        end
        wrap_up();
    end
endmodule
